// ### rtl/dps_pkg.sv
// Shared constants and carrier types for the dual-port static memory port controller
package dps_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 9;
   localparam int DEPTH = 4096;
   // Clock period and pin timing figures in nanoseconds
   localparam int CLK_PERIOD_NS = 8;
   localparam int T_ADDR_SETUP_NS = 0;
   localparam int T_WRITE_PULSE_NS = 20;
   localparam int T_WZ_NS = 11;
   localparam int T_DW_NS = 15;
   localparam int T_WR_NS = 2;
   localparam int T_DH_NS = 0;
   localparam int T_ACCESS_NS = 25;
   localparam int T_HZ_NS = 11;
   localparam int T_PASS_NS = 45;
   // Least times round up, never below one cycle
   function automatic int cyc_min(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int WP_OE_HI_CYC = cyc_min(T_WRITE_PULSE_NS);
   localparam int WP_OE_LO_CYC = cyc_min((T_WRITE_PULSE_NS > T_WZ_NS + T_DW_NS) ?
                                         T_WRITE_PULSE_NS : T_WZ_NS + T_DW_NS);
   localparam int SETUP_CYC = cyc_min(T_ADDR_SETUP_NS);
   localparam int RECOV_CYC = cyc_min((T_WR_NS > T_DH_NS) ? T_WR_NS : T_DH_NS);
   localparam int ACCESS_CYC = cyc_min(T_ACCESS_NS);
   localparam int HZ_CYC = cyc_min(T_HZ_NS);
   localparam int PASS_CYC = cyc_min(T_PASS_NS);
   localparam int CNT_W = 8;
   localparam int SYNC_STAGES = 3;
   // User request carrier
   typedef struct packed {
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } dps_req_s;
   // Pins toward one memory port
   typedef struct packed {
      logic rw_n;
      logic oe_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dout;
      logic data_oe;
   } dps_pin_s;
endpackage

// ### rtl/dps_sync.sv
// Three-stage synchroniser with agreement filter for a pin bus
`timescale 1ns/1ps
`default_nettype none
module dps_sync #(
   parameter int W = 9
) (
   input wire logic clk, // System clock
   input wire logic rstn, // Async reset, active low
   input wire logic [W-1:0] din, // Asynchronous pin value
   output logic [W-1:0] dout // Filtered value
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] out_q;
   // Stage one is read only by stage two
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   // Take a new value only once stages two and three agree per bit
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               out_q[i] <= 1'b0;
            end else if (s2_q[i] == s3_q[i]) begin
               out_q[i] <= s3_q[i];
            end
         end
      end
   endgenerate
   assign dout = out_q;
endmodule
`default_nettype wire

// ### rtl/dps_port_ctrl.sv
// Host-side controller that drives one port of an asynchronous dual-port static memory
//
// What the memory does and asks of its host
// [R01] The memory holds 4096 words of 9 bits reached by a 12-bit address and 9-bit data.
// [R02] A low read/write select stores the data bus into the addressed word whatever oe is.
// [R03] With select high and output enable low the memory drives the addressed word out.
// [R04] With output enable high the memory keeps its data pins floating.
// [R05] There is no chip select, so the port is always live and needs no wake-up.
// [R06] The two ports run on their own, each reaching any word without the other.
// [R07] Users must never write one word from both ports at once, as no arbiter exists.
// [R08] Read and write behaviour holds only when the two ports address different words.
// [R09] The driving party keeps read/write select high whenever the address changes.
// [R10] The host does not drive write data while the memory may still drive the pins.
// [R11] With oe low during a write the pulse is the larger of pulse width or turnoff plus setup.
// [R12] With oe high during a write the pulse may be as short as the least pulse width.
// [R13] Write data stays stable after the write ends for the hold time, zero at least.
// [R14] A word written on one port shows on the other port after a bounded pass-through delay.
`timescale 1ns/1ps
`default_nettype none
module dps_port_ctrl #(
   parameter int ADDR_W = dps_pkg::ADDR_W,
   parameter int DATA_W = dps_pkg::DATA_W,
   parameter bit OE_LOW_IN_WRITE = 1'b0
) (
   input wire logic clk, // System clock, 125 MHz
   input wire logic rstn, // Async reset, active low
   input wire logic req_valid, // Request offered
   output logic req_ready, // Request taken this cycle
   input wire dps_pkg::dps_req_s req, // Request body
   input wire logic peer_wait, // Wait for port-to-port pass-through after write
   output logic rsp_valid, // Read data or write done, one cycle
   output logic [DATA_W-1:0] rsp_rdata, // Read data
   output logic rsp_write, // Response belongs to a write
   output logic mem_rw_n, // Read/write select pin, low writes
   output logic mem_oe_n, // Output enable pin, active low
   output logic [ADDR_W-1:0] port_address_bus, // Address pins
   input wire logic [DATA_W-1:0] port_data_bus_i, // Data pins as seen
   output logic [DATA_W-1:0] port_data_bus_o, // Data pins driven by host
   output logic port_data_bus_oe // High while host drives data pins
);
   // Phases of one access; each phase is timed by the shared down-counter
   typedef enum logic [2:0] {
      ST_IDLE, ST_SETUP, ST_WPULSE, ST_RECOV, ST_RDWAIT, ST_RDEND, ST_PASS
   } dps_state_e;

   dps_state_e state_q;
   logic [dps_pkg::CNT_W-1:0] cnt_q;
   logic wr_q;
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] wdata_q;
   logic [DATA_W-1:0] rdata_q;
   logic rsp_valid_q;
   logic rsp_write_q;
   logic rw_n_q;
   logic oe_n_q;
   logic doe_q;
   logic [DATA_W-1:0] data_sync;
   logic cnt_done;

   localparam logic [dps_pkg::CNT_W-1:0] WP_CYC = dps_pkg::CNT_W'(OE_LOW_IN_WRITE ?
      dps_pkg::WP_OE_LO_CYC : dps_pkg::WP_OE_HI_CYC);
   localparam logic [dps_pkg::CNT_W-1:0] ONE = dps_pkg::CNT_W'(1);
   // Pulse count at which host data may go out with oe low, once memory turnoff is over
   localparam logic [dps_pkg::CNT_W-1:0] DRIVE_AT = WP_CYC -
      dps_pkg::CNT_W'(dps_pkg::HZ_CYC) + ONE; // [R11]

   // Data pins arrive from another timing domain, so filter them
   // The filter adds four cycles to the read path, three of which the access wait counts in
   dps_sync #(
      .W(DATA_W)
   ) u_sync (
      .clk(clk),
      .rstn(rstn),
      .din(port_data_bus_i),
      .dout(data_sync)
   );

   // A phase ends on the cycle its count reaches one
   assign cnt_done = (cnt_q == ONE);
   // Memory is always live, so a request can be taken straight from idle
   assign req_ready = (state_q == ST_IDLE); // [R05]

   // Sequencer; every phase length is counted down in cnt_q
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (req_valid) begin
                  state_q <= ST_SETUP;
                  // Turnoff wait covers memory drivers still on the bus
                  cnt_q <= dps_pkg::CNT_W'(req.write ?
                     dps_pkg::HZ_CYC : dps_pkg::SETUP_CYC); // [R10]
               end
            end
            ST_SETUP: begin
               if (cnt_done) begin
                  state_q <= wr_q ? ST_WPULSE : ST_RDWAIT;
                  cnt_q <= wr_q ? WP_CYC : dps_pkg::CNT_W'(dps_pkg::ACCESS_CYC +
                     dps_pkg::SYNC_STAGES); // [R11] [R12]
               end else begin
                  cnt_q <= cnt_q - ONE;
               end
            end
            ST_WPULSE: begin
               if (cnt_done) begin
                  state_q <= ST_RECOV;
                  cnt_q <= dps_pkg::CNT_W'(dps_pkg::RECOV_CYC);
               end else begin
                  cnt_q <= cnt_q - ONE;
               end
            end
            ST_RECOV: begin
               if (cnt_done) begin
                  // Peer wait holds this port off its next request while the written word passes to the far port
                  state_q <= peer_wait ? ST_PASS : ST_IDLE; // [R07]
                  cnt_q <= dps_pkg::CNT_W'(dps_pkg::PASS_CYC); // [R14]
               end else begin
                  cnt_q <= cnt_q - ONE;
               end
            end
            ST_RDWAIT: begin
               if (cnt_done) begin
                  state_q <= ST_RDEND;
                  cnt_q <= dps_pkg::CNT_W'(dps_pkg::HZ_CYC);
               end else begin
                  cnt_q <= cnt_q - ONE;
               end
            end
            ST_RDEND, ST_PASS: begin
               if (cnt_done) begin
                  state_q <= ST_IDLE;
               end else begin
                  cnt_q <= cnt_q - ONE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
               cnt_q <= '0;
            end
         endcase
      end
   end

   // Latch the request; address only moves in idle where select is high
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_q <= 1'b0;
         addr_q <= '0;
         wdata_q <= '0;
      end else if (state_q == ST_IDLE && req_valid) begin
         wr_q <= req.write;
         addr_q <= req.addr[ADDR_W-1:0]; // [R01] [R09]
         wdata_q <= req.wdata[DATA_W-1:0];
      end
   end

   // Select low only during the pulse; it stays high across any address change
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rw_n_q <= 1'b1;
      end else begin
         rw_n_q <= !((state_q == ST_SETUP && cnt_done && wr_q) ||
                     (state_q == ST_WPULSE && !cnt_done)); // [R02] [R09]
      end
   end

   // Output enable low for reads, and in writes only if strapped that way
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         oe_n_q <= 1'b1;
      end else begin
         case (state_q)
            ST_IDLE: oe_n_q <= !(req_valid && (!req.write || OE_LOW_IN_WRITE)); // [R03]
            ST_RDWAIT: oe_n_q <= cnt_done; // [R04]
            ST_SETUP, ST_WPULSE: oe_n_q <= oe_n_q;
            default: oe_n_q <= 1'b1;
         endcase
      end
   end

   // Drive data only after memory turnoff and hold it through recovery.
   // With oe low in writes the memory drives until the select fall turns it off,
   // so the host holds its data back for the turnoff cycles of the pulse.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         doe_q <= 1'b0;
      end else begin
         doe_q <= wr_q && ((state_q == ST_SETUP && cnt_done && !OE_LOW_IN_WRITE) ||
                  (state_q == ST_WPULSE && (!OE_LOW_IN_WRITE || cnt_q <= DRIVE_AT)) ||
                  (state_q == ST_RECOV && !cnt_done)); // [R10] [R11] [R13]
      end
   end

   // Capture read data at the end of the access wait and report completion
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= '0;
         rsp_valid_q <= 1'b0;
         rsp_write_q <= 1'b0;
      end else begin
         rsp_valid_q <= (state_q == ST_RDWAIT && cnt_done) ||
                        (state_q == ST_RECOV && cnt_done); // [R06]
         rsp_write_q <= (state_q == ST_RECOV);
         if (state_q == ST_RDWAIT && cnt_done) begin
            rdata_q <= data_sync; // [R03]
         end
      end
   end

   // Every pin comes straight from a flip-flop, so no decode glitch reaches the memory
   assign mem_rw_n = rw_n_q;
   assign mem_oe_n = oe_n_q;
   assign port_address_bus = addr_q;
   assign port_data_bus_o = wdata_q;
   assign port_data_bus_oe = doe_q;
   assign rsp_valid = rsp_valid_q;
   assign rsp_rdata = rdata_q;
   assign rsp_write = rsp_write_q;
endmodule
`default_nettype wire

// ### testbench/dps_port_ctrl_properties.sv
// Pin timing checker bound to the memory port controller
`timescale 1ns/1ps
`default_nettype none
module dps_port_ctrl_chk #(
   parameter int ADDR_W = dps_pkg::ADDR_W,
   parameter int DATA_W = dps_pkg::DATA_W
) (
   input wire logic clk, // Clock
   input wire logic rstn, // Reset, active low
   input wire logic rsp_valid, // Answer pulse
   input wire logic rsp_write, // Answer is a write
   input wire logic mem_rw_n, // Select pin
   input wire logic mem_oe_n, // Enable pin
   input wire logic [ADDR_W-1:0] port_address_bus, // Address pins
   input wire logic [DATA_W-1:0] port_data_bus_o, // Host data
   input wire logic port_data_bus_oe // Host drives data
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // Pulse of three cycles, then recovery
   sequence wr_pulse_s;
      !mem_rw_n [*3] ##1 mem_rw_n;
   endsequence
   // Data held through the pulse and recovery, as hold time needs
   sequence wr_hold_s;
      (port_data_bus_oe && $stable(port_data_bus_o)) [*3];
   endsequence
   wr_pulse_a: assert property ($fell(mem_rw_n) |-> wr_pulse_s)
      else $error("write pulse length wrong");
   wr_hold_a: assert property ($fell(mem_rw_n) |=> wr_hold_s)
      else $error("write data not held");
   addr_move_a: assert property (!$stable(port_address_bus) |-> mem_rw_n && $past(mem_rw_n))
      else $error("address moved while writing");
   host_drive_a: assert property (port_data_bus_oe |-> mem_oe_n)
      else $error("host drives while memory may drive");
   wr_data_a: assert property (!mem_rw_n |-> port_data_bus_oe)
      else $error("write pulse without data");
   wr_done_a: assert property ($rose(mem_rw_n) |=> rsp_valid && rsp_write)
      else $error("write answer missing");
   rd_enable_a: assert property (rsp_valid && !rsp_write |->
      !$past(mem_oe_n) && !$past(mem_oe_n, 4) && mem_rw_n)
      else $error("read answer without output enable");
   oe_read_a: assert property (!mem_oe_n |-> mem_rw_n)
      else $error("output enable during write");
endmodule
bind dps_port_ctrl dps_port_ctrl_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (.clk(clk),
   .rstn(rstn), .rsp_valid(rsp_valid), .rsp_write(rsp_write), .mem_rw_n(mem_rw_n),
   .mem_oe_n(mem_oe_n), .port_address_bus(port_address_bus),
   .port_data_bus_o(port_data_bus_o), .port_data_bus_oe(port_data_bus_oe));
`default_nettype wire

// ### testbench/dps_mem_model.sv
// Behavioural dual-port memory with one pin port and one opposite strobe port
`timescale 1ns/1ps
`default_nettype none
module dps_mem_model #(
   parameter int ACC_NS = 20
) (
   input wire logic rw_n, // Select, low writes
   input wire logic oe_n, // Output enable, active low
   input wire logic [11:0] addr, // Address pins
   input wire logic [8:0] host_d, // Host data
   input wire logic host_oe, // Host drives data
   input wire logic b_we, // Opposite port strobe
   input wire logic [11:0] b_addr, // Opposite port address
   input wire logic [8:0] b_d, // Opposite port data
   output logic [8:0] bus // Resolved data pins
);
   logic [8:0] mem [4096];
   logic [8:0] rd;
   // No chip select: store at pulse end, oe ignored
   always @(posedge rw_n) mem[addr] = host_d;
   always @(posedge b_we) mem[b_addr] = b_d;
   assign #(ACC_NS) rd = mem[addr];
   // Floating pins show the inverse word so a stale value cannot pass
   assign bus = host_oe ? host_d : (rw_n && !oe_n) ? rd : ~rd;
endmodule
`default_nettype wire

// ### testbench/tb_dps_port_ctrl.sv
// Self-checking bench for the memory port controller
`timescale 1ns/1ps
`default_nettype none
module tb_dps_port_ctrl;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic req_valid = 1'b0;
   logic peer_wait = 1'b0;
   logic b_we = 1'b0;
   logic [11:0] b_addr = 12'h000;
   logic [8:0] b_d = 9'h000;
   dps_pkg::dps_req_s req = '0;
   logic req_ready, rsp_valid, rsp_write, mem_rw_n, mem_oe_n, port_data_bus_oe;
   logic [11:0] port_address_bus;
   logic [8:0] rsp_rdata, port_data_bus_o, bus;
   int bad_count = 0;
   int compares = 0;
   always #4 clk = ~clk;
   dps_port_ctrl u_dps_port_ctrl (.clk(clk), .rstn(rstn), .req_valid(req_valid),
      .req_ready(req_ready), .req(req), .peer_wait(peer_wait), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .rsp_write(rsp_write), .mem_rw_n(mem_rw_n), .mem_oe_n(mem_oe_n),
      .port_address_bus(port_address_bus), .port_data_bus_i(bus),
      .port_data_bus_o(port_data_bus_o), .port_data_bus_oe(port_data_bus_oe));
   dps_mem_model u_dps_mem_model (.rw_n(mem_rw_n), .oe_n(mem_oe_n), .addr(port_address_bus),
      .host_d(port_data_bus_o), .host_oe(port_data_bus_oe), .b_we(b_we), .b_addr(b_addr),
      .b_d(b_d), .bus(bus));
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic tmo(input int n);
      if (n >= 40) begin
         bad_count++;
         report_and_stop();
      end
   endtask
   // Offer held until ready, seen at the falling edge before the taking edge
   task automatic xfer(input logic w, input logic [11:0] a, input logic [8:0] d,
                       output logic [8:0] q);
      int n;
      @(negedge clk);
      req = '{write: w, addr: a, wdata: d};
      req_valid = 1'b1;
      for (n = 0; n < 40 && req_ready !== 1'b1; n++) @(negedge clk);
      tmo(n);
      @(negedge clk);
      req_valid = 1'b0;
      for (n = 0; n < 40 && rsp_valid !== 1'b1; n++) @(negedge clk);
      tmo(n);
      check({8'h00, rsp_write}, {8'h00, w});
      q = rsp_rdata;
   endtask
   // Corner addresses with all-ones, top-bit and alternating data words
   task automatic t_edges();
      logic [11:0] a [3] = '{12'h000, 12'hFFF, 12'h800};
      logic [8:0] d [3] = '{9'h1FF, 9'h100, 9'h0AA};
      logic [8:0] q;
      for (int i = 0; i < 3; i++) xfer(1'b1, a[i], d[i], q);
      for (int i = 0; i < 3; i++) begin
         xfer(1'b0, a[i], 9'h000, q);
         check(q, d[i]);
      end
   endtask
   // Back-to-back writes, the second waiting out pass-through
   task automatic t_overwrite();
      logic [8:0] q;
      int n;
      xfer(1'b1, 12'h123, 9'h055, q);
      peer_wait = 1'b1;
      xfer(1'b1, 12'h123, 9'h1AA, q);
      for (n = 0; n < 40 && req_ready !== 1'b1; n++) @(negedge clk);
      tmo(n);
      check(9'(n), 9'(dps_pkg::PASS_CYC));
      xfer(1'b0, 12'h123, 9'h000, q);
      peer_wait = 1'b0;
      check(q, 9'h1AA);
   endtask
   // Word stored by the opposite port is read here
   task automatic t_other_port();
      logic [8:0] q;
      @(negedge clk);
      b_addr = 12'h456;
      b_d = 9'h133;
      b_we = 1'b1;
      @(negedge clk);
      b_we = 1'b0;
      xfer(1'b0, 12'h456, 9'h000, q);
      check(q, 9'h133);
   endtask
   // Reset in mid-write parks every pin and leaves the port ready
   task automatic t_mid_reset();
      int n;
      @(negedge clk);
      req = '{write: 1'b1, addr: 12'h9AB, wdata: 9'h077};
      req_valid = 1'b1;
      for (n = 0; n < 40 && req_ready !== 1'b1; n++) @(negedge clk);
      tmo(n);
      @(negedge clk);
      req_valid = 1'b0;
      repeat (2) @(negedge clk);
      check({8'h00, mem_rw_n}, 9'h000);
      rstn = 1'b0;
      @(negedge clk);
      check({4'h0, req_ready, mem_rw_n, mem_oe_n, rsp_valid, port_data_bus_oe}, 9'h01C);
      repeat (2) @(negedge clk);
      rstn = 1'b1;
   endtask
   initial begin
      repeat (20) @(negedge clk);
      rstn = 1'b1;
      t_edges();
      t_overwrite();
      t_other_port();
      t_mid_reset();
      t_edges();
      report_and_stop();
   end
endmodule
`default_nettype wire
